// File: rtl/dap_pkg.sv
// constants and types for the dsp accumulator pair
package dap_pkg;
	localparam int STORED_W = 72;
	localparam int VIEW_W = 96;
	localparam int WORD_W = 32;
	localparam int SIGN_BIT = 71;
	localparam int GUARD_LO = 64;
	localparam int HIGH_LO = 32;
	localparam int MID_LO = 16;
	localparam int LOW_LO = 0;
	localparam int GUARD_KEEP_W = 8;
	// move operation codes
	typedef enum logic [2:0] {
		DAP_OP_NONE = 3'h0,
		DAP_OP_GUARD_WRITE = 3'h1,
		DAP_OP_HIGH_WRITE = 3'h2,
		DAP_OP_LOW_WRITE = 3'h3,
		DAP_OP_GUARD_READ = 3'h4,
		DAP_OP_HIGH_READ = 3'h5,
		DAP_OP_MIDDLE_READ = 3'h6,
		DAP_OP_LOW_READ = 3'h7
	} dap_op_t;
	localparam logic SEL_FIRST = 1'h0;
	localparam logic SEL_SECOND = 1'h1;
endpackage : dap_pkg

// File: rtl/dap_view.sv
// 96-bit sign-extended view of one stored 72-bit accumulator
`timescale 1ns/1ps
module dap_view #(
	parameter int STORED_W = dap_pkg::STORED_W,
	parameter int VIEW_W = dap_pkg::VIEW_W
) (
	// stored value
	input wire logic [STORED_W-1:0] stored,
	// widened value
	output logic [VIEW_W-1:0] view
);
	// replicate the top stored bit into the upper view bits
	assign view = {{(VIEW_W-STORED_W){stored[STORED_W-1]}}, stored};
endmodule : dap_view

// File: rtl/dap_accumulator_pair.sv
// dsp accumulator pair: two 72-bit accumulators with 32-bit move windows
`timescale 1ns/1ps
module dap_accumulator_pair #(
	parameter int STORED_W = dap_pkg::STORED_W,
	parameter int WORD_W = dap_pkg::WORD_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// move operation request
	input wire logic move_valid,
	input wire dap_pkg::dap_op_t move_op,
	input wire logic move_sel,
	input wire logic [WORD_W-1:0] move_wdata,
	// move read result
	output logic [WORD_W-1:0] move_rdata_q,
	output logic move_rvalid_q,
	// product result into the first accumulator
	input wire logic product_valid,
	input wire logic [STORED_W-1:0] product_result,
	// full views of both accumulators
	output logic [dap_pkg::VIEW_W-1:0] first_accumulator_view,
	output logic [dap_pkg::VIEW_W-1:0] second_accumulator_view
);
	// stored state of the two accumulators
	logic [STORED_W-1:0] first_accumulator_q;
	logic [STORED_W-1:0] second_accumulator_q;

	// sign-extended view of the accumulator picked by the operand
	logic [dap_pkg::VIEW_W-1:0] sel_view;

	// decoded move kinds, already qualified by move_valid
	logic is_write;
	logic is_read;

	// write hits, one per accumulator
	logic write_first;
	logic write_second;

	// window picked out of the selected view
	logic [WORD_W-1:0] read_word;

	// true for the three window write codes
	function automatic logic op_is_write(
		input dap_pkg::dap_op_t op
	);
		logic hit;
		hit = 1'h0;
		unique case (op)
			// guard, high and low windows can be written
			dap_pkg::DAP_OP_GUARD_WRITE: hit = 1'h1;
			dap_pkg::DAP_OP_HIGH_WRITE: hit = 1'h1;
			dap_pkg::DAP_OP_LOW_WRITE: hit = 1'h1;
			// reads and the idle code leave storage alone
			default: hit = 1'h0;
		endcase
		return hit;
	endfunction : op_is_write

	// true for the four window read codes
	function automatic logic op_is_read(
		input dap_pkg::dap_op_t op
	);
		logic hit;
		hit = 1'h0;
		unique case (op)
			// guard, high, middle and low windows can be read
			dap_pkg::DAP_OP_GUARD_READ: hit = 1'h1;
			dap_pkg::DAP_OP_HIGH_READ: hit = 1'h1;
			dap_pkg::DAP_OP_MIDDLE_READ: hit = 1'h1;
			dap_pkg::DAP_OP_LOW_READ: hit = 1'h1;
			// writes and the idle code return nothing
			default: hit = 1'h0;
		endcase
		return hit;
	endfunction : op_is_read

	// merge a 32-bit word into a window of a stored accumulator
	function automatic logic [STORED_W-1:0] merge_word(
		input logic [STORED_W-1:0] cur,
		input dap_pkg::dap_op_t op,
		input logic [WORD_W-1:0] w
	);
		logic [STORED_W-1:0] nxt;
		nxt = cur;
		unique case (op)
			dap_pkg::DAP_OP_GUARD_WRITE: begin
				// upper 24 bits of the word land beyond storage and are dropped
				nxt[dap_pkg::GUARD_LO +: dap_pkg::GUARD_KEEP_W] =
					w[dap_pkg::GUARD_KEEP_W-1:0];
			end
			dap_pkg::DAP_OP_HIGH_WRITE: begin
				// the whole word fits inside storage
				nxt[dap_pkg::HIGH_LO +: WORD_W] = w;
			end
			dap_pkg::DAP_OP_LOW_WRITE: begin
				// the whole word fits inside storage
				nxt[dap_pkg::LOW_LO +: WORD_W] = w;
			end
			default: begin
				// no write window: keep the old contents
				nxt = cur;
			end
		endcase
		return nxt;
	endfunction : merge_word

	// pick the 32-bit read window out of a widened view
	function automatic logic [WORD_W-1:0] read_window(
		input logic [dap_pkg::VIEW_W-1:0] v,
		input dap_pkg::dap_op_t op
	);
		logic [WORD_W-1:0] word;
		word = v[dap_pkg::LOW_LO +: WORD_W];
		unique case (op)
			dap_pkg::DAP_OP_GUARD_READ: begin
				// upper bits come from the sign copies of the view
				word = v[dap_pkg::GUARD_LO +: WORD_W];
			end
			dap_pkg::DAP_OP_HIGH_READ: begin
				word = v[dap_pkg::HIGH_LO +: WORD_W];
			end
			dap_pkg::DAP_OP_MIDDLE_READ: begin
				// fixed-point product without a separate shift
				word = v[dap_pkg::MID_LO +: WORD_W];
			end
			default: begin
				word = v[dap_pkg::LOW_LO +: WORD_W];
			end
		endcase
		return word;
	endfunction : read_window

	// widened view of the first accumulator
	dap_view #(
		.STORED_W(STORED_W),
		.VIEW_W(dap_pkg::VIEW_W)
	) u_view_first (
		.stored(first_accumulator_q),
		.view(first_accumulator_view)
	);

	// widened view of the second accumulator
	dap_view #(
		.STORED_W(STORED_W),
		.VIEW_W(dap_pkg::VIEW_W)
	) u_view_second (
		.stored(second_accumulator_q),
		.view(second_accumulator_view)
	);

	// decode of the move kind
	assign is_write = move_valid && op_is_write(move_op);
	assign is_read = move_valid && op_is_read(move_op);

	// route a write to exactly one accumulator
	assign write_first = is_write && (move_sel == dap_pkg::SEL_FIRST);
	assign write_second = is_write && (move_sel == dap_pkg::SEL_SECOND);

	// reads see the operand-selected accumulator
	assign sel_view = (move_sel == dap_pkg::SEL_SECOND) ? second_accumulator_view
		: first_accumulator_view;
	assign read_word = read_window(sel_view, move_op);

	// first accumulator: product result wins over a same-cycle move write
	// the move write is dropped, since the product overwrites all stored bits
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			first_accumulator_q <= '0;
		end else if (product_valid) begin
			first_accumulator_q <= product_result;
		end else if (write_first) begin
			first_accumulator_q <= merge_word(first_accumulator_q, move_op, move_wdata);
		end
	end

	// second accumulator: touched only by moves that select it
	// products never reach it, so it is a plain holding register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			second_accumulator_q <= '0;
		end else if (write_second) begin
			second_accumulator_q <= merge_word(second_accumulator_q, move_op, move_wdata);
		end
	end

	// read strobe: one cycle after each read request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			move_rvalid_q <= 1'h0;
		end else begin
			move_rvalid_q <= is_read;
		end
	end

	// read data: holds the last window until the next read
	// taken from pre-edge contents when a write hits the same edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			move_rdata_q <= '0;
		end else if (is_read) begin
			move_rdata_q <= read_word;
		end
	end
endmodule : dap_accumulator_pair

// File: sim/dap_core_model.sv
// execution-side model issuing products
`timescale 1ns/1ps
module dap_core_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// issue request from the bench
	input wire logic issue,
	input wire logic [71:0] value,
	// product toward the accumulators
	output logic product_valid,
	output logic [71:0] product_result
);
	// one-cycle product, bus inverted when idle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			product_valid <= 0;
			product_result <= 0;
		end else begin
			product_valid <= issue;
			product_result <= issue ? value : ~product_result;
		end
	end
endmodule : dap_core_model

// File: sim/dap_accumulator_pair_properties.sv
// port checker for the accumulator pair
`timescale 1ns/1ps
module dap_accumulator_pair_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// move request and result
	input wire logic move_valid,
	input wire dap_pkg::dap_op_t move_op,
	input wire logic move_sel,
	input wire logic [31:0] move_wdata,
	input wire logic [31:0] move_rdata_q,
	input wire logic move_rvalid_q,
	// product load
	input wire logic product_valid,
	input wire logic [71:0] product_result,
	// widened views
	input wire logic [95:0] first_accumulator_view,
	input wire logic [95:0] second_accumulator_view
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_first_sign_ext: assert property (first_accumulator_view[95:72] ==
		{24{first_accumulator_view[71]}}) else $error("first sign");
	chk_second_sign_ext: assert property (second_accumulator_view[95:72] ==
		{24{second_accumulator_view[71]}}) else $error("second sign");
	chk_read_strobe: assert property (move_valid && move_op[2] |=> move_rvalid_q)
		else $error("no strobe");
	chk_idle_strobe: assert property (!(move_valid && move_op[2]) |=> !move_rvalid_q)
		else $error("stray strobe");
	chk_middle_read: assert property (move_valid && move_op == dap_pkg::DAP_OP_MIDDLE_READ
		&& move_sel |=> move_rdata_q == $past(second_accumulator_view[47:16]))
		else $error("middle");
	chk_product_load: assert property (product_valid |=>
		first_accumulator_view[71:0] == $past(product_result)) else $error("product");
	chk_guard_keep: assert property (move_valid && move_op == dap_pkg::DAP_OP_GUARD_WRITE
		&& move_sel |=> second_accumulator_view[71:64] == $past(move_wdata[7:0]))
		else $error("guard");
	chk_second_kept: assert property (!(move_valid && move_sel && !move_op[2] && move_op != 0)
		|=> $stable(second_accumulator_view)) else $error("second changed");
endmodule : dap_accumulator_pair_properties
bind dap_accumulator_pair dap_accumulator_pair_properties dap_accumulator_pair_properties_i (.*);

// File: sim/dap_accumulator_pair_bench.sv
// bench for the accumulator pair
`timescale 1ns/1ps
module dap_accumulator_pair_bench;
	logic sys_clk = 0, nrst = 0, move_valid = 0, move_sel = 0, issue = 0, move_rvalid_q;
	dap_pkg::dap_op_t move_op = dap_pkg::DAP_OP_NONE;
	logic [31:0] move_wdata = 0, move_rdata_q;
	logic [71:0] value = 0, product_result;
	logic product_valid;
	logic [95:0] first_accumulator_view, second_accumulator_view;
	int error_cnt = 0, cmp_count = 0;
	initial forever #4 sys_clk = ~sys_clk;
	dap_accumulator_pair dap_accumulator_pair_i (.*);
	dap_core_model dap_core_model_i (.*);
	task automatic chk(input logic [95:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle move request
	task automatic mv(input dap_pkg::dap_op_t o, input logic s, input logic [31:0] w);
		@(posedge sys_clk); #1 move_valid = 1; move_op = o; move_sel = s; move_wdata = w;
		@(posedge sys_clk); #1 move_valid = 0;
	endtask : mv
	task automatic windows_test;
		mv(dap_pkg::DAP_OP_HIGH_WRITE, 1, 32'h8000_0001);
		mv(dap_pkg::DAP_OP_LOW_WRITE, 1, 32'h1234_5678);
		mv(dap_pkg::DAP_OP_GUARD_WRITE, 1, 32'h0000_1280);
		mv(dap_pkg::DAP_OP_GUARD_READ, 1, 0); chk(move_rdata_q, 32'hFFFF_FF80);
		mv(dap_pkg::DAP_OP_HIGH_READ, 1, 0); chk(move_rdata_q, 32'h8000_0001);
		mv(dap_pkg::DAP_OP_MIDDLE_READ, 1, 0); chk(move_rdata_q, 32'h0001_1234);
		mv(dap_pkg::DAP_OP_LOW_READ, 1, 0); chk(move_rdata_q, 32'h1234_5678);
		chk(second_accumulator_view, 96'hFFFF_FF80_8000_0001_1234_5678);
		chk(first_accumulator_view, 0);
		$display("windows test done");
	endtask : windows_test
	task automatic product_test;
		@(posedge sys_clk); #1 issue = 1; value = 72'h12_3456_789A_BCDE_F012;
		@(posedge sys_clk); #1 issue = 0;
		mv(dap_pkg::DAP_OP_GUARD_READ, 0, 0); chk(move_rdata_q, 32'h0000_0012);
		$display("product test done");
	endtask : product_test
	// product and first-accumulator write on one edge; then a write to the first only
	task automatic collide_test;
		@(posedge sys_clk); #1 issue = 1; value = 72'h80_0000_0000_0000_0001;
		@(posedge sys_clk); #1 issue = 0; move_valid = 1; move_op = dap_pkg::DAP_OP_LOW_WRITE;
		move_sel = 0; move_wdata = 32'hDEAD_BEEF;
		@(posedge sys_clk); #1 move_valid = 0;
		chk(first_accumulator_view, 96'hFFFF_FF80_0000_0000_0000_0001);
		chk(second_accumulator_view, 96'hFFFF_FF80_8000_0001_1234_5678);
		mv(dap_pkg::DAP_OP_HIGH_WRITE, 0, 32'hCAFE_0000);
		chk(second_accumulator_view, 96'hFFFF_FF80_8000_0001_1234_5678);
		mv(dap_pkg::DAP_OP_LOW_READ, 0, 0); chk(move_rvalid_q, 1);
		chk(move_rdata_q, 32'h0000_0001);
		@(posedge sys_clk); #1 chk(move_rvalid_q, 0);
		mv(dap_pkg::DAP_OP_HIGH_READ, 0, 0); chk(move_rdata_q, 32'hCAFE_0000);
		$display("collide test done");
	endtask : collide_test
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 nrst = 1;
		windows_test();
		product_test();
		collide_test();
		final_report();
	end
endmodule : dap_accumulator_pair_bench
